// ===== shared/ddr2_timing2_map.vh
// Register offsets, field positions, reset values, unlock bit and response codes of the timing block
`ifndef DDR2_TIMING2_MAP_VH
`define DDR2_TIMING2_MAP_VH

// Byte offsets on the register bus
`define OFS_TIMING_SECOND 5'h00
`define OFS_STARVE_PRIO 5'h04
`define OFS_CONFIG 5'h08
`define OFS_STATUS 5'h0C

// Second timing register fields
`define ODT_HI 24
`define ODT_LO 23
`define XSNR_HI 22
`define XSNR_LO 16
`define XSRD_HI 15
`define XSRD_LO 8
`define RTP_HI 7
`define RTP_LO 5
`define CKE_HI 4
`define CKE_LO 0

// Reset values
`define ODT_RST 2'h3
`define XSNR_RST 7'h7F
`define XSRD_RST 8'hFF
`define RTP_RST 3'h7
`define CKE_RST 5'h1F
`define PRIO_RST 8'hFF
`define PRIO_OFF 8'hFF

// Configuration register: timing unlock bit
`define UNLOCK_BIT 15

// AXI response codes
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== src/starve_promoter.v
// Anti-starvation counter that promotes the oldest queued command
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing2_map.vh"

module starve_promoter (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire [7:0] promotion_transfer_threshold,
    input wire transfer_done,
    output reg promote_oldest
);
    reg [7:0] count_q;
    wire disabled = (promotion_transfer_threshold == `PRIO_OFF);

    // Count transfers; field value plus one transfers trip one promotion pulse
    always @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= 8'h00;
            promote_oldest <= 1'b0;
        end else if (clk_en) begin
            promote_oldest <= 1'b0;
            if (disabled) begin
                count_q <= 8'h00;
            end else if (transfer_done) begin
                if (count_q >= promotion_transfer_threshold) begin
                    count_q <= 8'h00;
                    promote_oldest <= 1'b1;
                end else begin
                    count_q <= count_q + 8'h01;
                end
            end
        end
    end
endmodule // starve_promoter

`default_nettype wire

// ===== src/ddr2_timing2_regs.v
// Second timing and burst priority registers with an AXI4-Lite slave
//
// Functional notes
// - The second timing register is writable only while the timing unlock bit is set.
// - Reserved upper bits of both registers read zero and ignore writes.
// - Bits 24-23 give the lead from termination enable to write data, in memory clocks.
// - Bits 22-16 give self-refresh exit to non-read command spacing, minus one.
// - Bits 15-8 give self-refresh exit to read command spacing, minus one.
// - Bits 7-5 give last read to precharge spacing, minus one.
// - Bits 4-0 give spacing between clock-enable output transitions, minus one.
// - The oldest queued command is briefly promoted after a programmed transfer count.
// - The threshold field encodes value plus one transfers.
// - A threshold of FFh disables forced promotion.
// - Timing fields and threshold reset to their maximum values.
//
// Added by the designer: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing2_map.vh"

module ddr2_timing2_regs (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire [4:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [4:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire transfer_done,
    output reg [1:0] odt_to_write_lead,
    output reg [6:0] selfref_exit_nonread_gap,
    output reg [7:0] selfref_exit_read_gap,
    output reg [2:0] read_to_precharge_gap,
    output reg [4:0] clock_enable_gap,
    output reg [7:0] promotion_transfer_threshold,
    output wire promote_oldest
);
    // Captured write address and data, either may arrive first
    reg aw_full_q;
    reg w_full_q;
    reg [4:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg timing_write_unlock;
    reg locked_drop_q;

    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready = !w_full_q && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;

    // Byte-lane merge of the write data over the present value
    function [31:0] merge;
        input [31:0] old;
        input [31:0] nw;
        input [3:0] strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = nw[i*8 +: 8];
                end
            end
        end
    endfunction

    wire [31:0] timing_word = {7'h00, odt_to_write_lead, selfref_exit_nonread_gap,
        selfref_exit_read_gap, read_to_precharge_gap, clock_enable_gap};
    wire [31:0] timing_new = merge(timing_word, w_data_q, w_strb_q);
    wire [31:0] prio_new = merge({24'h000000, promotion_transfer_threshold},
        w_data_q, w_strb_q);
    wire [31:0] cfg_word = {16'h0000, timing_write_unlock, 15'h0000};
    wire [31:0] cfg_new = merge(cfg_word, w_data_q, w_strb_q);
    wire [31:0] status_word = {31'h00000000, locked_drop_q};

    // Write channel: capture, apply, respond
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 5'h00;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            timing_write_unlock <= 1'b0;
            locked_drop_q <= 1'b0;
            odt_to_write_lead <= `ODT_RST;
            selfref_exit_nonread_gap <= `XSNR_RST;
            selfref_exit_read_gap <= `XSRD_RST;
            read_to_precharge_gap <= `RTP_RST;
            clock_enable_gap <= `CKE_RST;
            promotion_transfer_threshold <= `PRIO_RST;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `RESP_OKAY;
                if (aw_addr_q[4:2] == `OFS_TIMING_SECOND >> 2) begin
                    if (timing_write_unlock) begin
                        odt_to_write_lead <= timing_new[`ODT_HI:`ODT_LO];
                        selfref_exit_nonread_gap <= timing_new[`XSNR_HI:`XSNR_LO];
                        selfref_exit_read_gap <= timing_new[`XSRD_HI:`XSRD_LO];
                        read_to_precharge_gap <= timing_new[`RTP_HI:`RTP_LO];
                        clock_enable_gap <= timing_new[`CKE_HI:`CKE_LO];
                    end else begin
                        // Dropped silently; sticky flag lets software notice
                        locked_drop_q <= 1'b1;
                    end
                end else if (aw_addr_q[4:2] == `OFS_STARVE_PRIO >> 2) begin
                    promotion_transfer_threshold <= prio_new[7:0];
                end else if (aw_addr_q[4:2] == `OFS_CONFIG >> 2) begin
                    timing_write_unlock <= cfg_new[`UNLOCK_BIT];
                end else if (aw_addr_q[4:2] == `OFS_STATUS >> 2) begin
                    // Write one to clear the drop flag
                    if (w_strb_q[0] && w_data_q[0]) begin
                        locked_drop_q <= 1'b0;
                    end
                end else begin
                    s_axi_bresp <= `RESP_SLVERR;
                end
            end
        end
    end

    // Read channel: one-cycle answer after the address is taken
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (clk_en) begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= `RESP_OKAY;
                if (s_axi_araddr[4:2] == `OFS_TIMING_SECOND >> 2) begin
                    s_axi_rdata <= timing_word;
                end else if (s_axi_araddr[4:2] == `OFS_STARVE_PRIO >> 2) begin
                    s_axi_rdata <= {24'h000000, promotion_transfer_threshold};
                end else if (s_axi_araddr[4:2] == `OFS_CONFIG >> 2) begin
                    s_axi_rdata <= cfg_word;
                end else if (s_axi_araddr[4:2] == `OFS_STATUS >> 2) begin
                    s_axi_rdata <= status_word;
                end else begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            end
        end
    end

    // Promotion logic runs off the live threshold field
    starve_promoter u_promoter (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .promotion_transfer_threshold(promotion_transfer_threshold),
        .transfer_done(transfer_done),
        .promote_oldest(promote_oldest)
    );
endmodule // ddr2_timing2_regs

`default_nettype wire

// ===== sim/sdram_xfer_model.sv
// Memory side model that completes a burst of transfers on request
`timescale 1ns/1ps
`default_nettype none
module sdram_xfer_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [9:0] burst,
    input wire logic start,
    output logic transfer_done
);
    logic [9:0] left_q;
    // One transfer completes in each cycle while the burst lasts
    always_ff @(posedge aclk) begin
        if (!aresetn) left_q <= 10'h000;
        else if (start) left_q <= burst;
        else if (left_q != 10'h000) left_q <= left_q - 10'h001;
    end
    assign transfer_done = left_q != 10'h000;
endmodule // sdram_xfer_model
`default_nettype wire

// ===== sim/ddr2_timing2_monitor.sv
// Port-level assertions for the timing register block
`timescale 1ns/1ps
`default_nettype none
module ddr2_timing2_monitor (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire transfer_done,
    input wire [1:0] odt_to_write_lead,
    input wire [6:0] selfref_exit_nonread_gap,
    input wire [7:0] selfref_exit_read_gap,
    input wire [2:0] read_to_precharge_gap,
    input wire [4:0] clock_enable_gap,
    input wire [7:0] promotion_transfer_threshold,
    input wire promote_oldest
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire wr_hs = s_axi_wvalid && s_axi_wready;
    wire [24:0] flds = {odt_to_write_lead, selfref_exit_nonread_gap, selfref_exit_read_gap,
        read_to_precharge_gap, clock_enable_gap};
    a_reset_max_values: assert property ($rose(aresetn) |-> flds == 25'h1FFFFFF
        && promotion_transfer_threshold == 8'hFF) else $error("reset values wrong");
    a_fields_need_write: assert property ($past(aresetn) && $changed(flds)
        |-> $past(wr_hs, 1) || $past(wr_hs, 2)) else $error("field changed without write");
    a_prio_off_quiet: assert property (promotion_transfer_threshold == 8'hFF
        && $past(promotion_transfer_threshold, 2) == 8'hFF |-> !promote_oldest)
        else $error("promotion while disabled");
    a_single_xfer_promo: assert property (promotion_transfer_threshold == 8'h00
        && transfer_done && clk_en |-> ##[1:2] promote_oldest) else $error("no promotion");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready && clk_en
        |=> s_axi_rvalid) else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && wr_hs && clk_en
        |-> ##[1:2] s_axi_bvalid) else $error("write not answered");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready) else $error("aw taken");
    c_write: cover property (wr_hs);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_promote: cover property (promote_oldest);
endmodule // ddr2_timing2_monitor
bind ddr2_timing2_regs ddr2_timing2_monitor mon (.aclk, .aresetn, .clk_en, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .transfer_done, .odt_to_write_lead, .selfref_exit_nonread_gap,
    .selfref_exit_read_gap, .read_to_precharge_gap, .clock_enable_gap,
    .promotion_transfer_threshold, .promote_oldest);
`default_nettype wire

// ===== sim/ddr2_timing2_and_burst_priority_tb_top.sv
// Self-checking bench for the timing and burst priority registers
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_timing2_map.vh"
module ddr2_timing2_and_burst_priority_tb_top;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bv, br = 0, arv = 0, rv, rr = 0;
    logic awr, wr, arr, td, go = 0, pr, ce = 1;
    logic [4:0] awa = 5'h00, ara = 5'h00;
    logic [31:0] wd = 32'h0, rd, d;
    logic [1:0] bresp, rresp, odt, s;
    logic [6:0] xsnr;
    logic [7:0] xsrd, thr;
    logic [2:0] rtp;
    logic [4:0] cke;
    logic [9:0] nb = 10'h000;
    int n_errors = 0, checks = 0, n_pulse = 0;
    always #25 aclk = ~aclk;
    // Count promotion pulses seen by the bench
    always @(posedge aclk) if (pr === 1'b1) n_pulse++;
    ddr2_timing2_regs DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(ce), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
        .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .transfer_done(td), .odt_to_write_lead(odt), .selfref_exit_nonread_gap(xsnr),
        .selfref_exit_read_gap(xsrd), .read_to_precharge_gap(rtp), .clock_enable_gap(cke),
        .promotion_transfer_threshold(thr), .promote_oldest(pr));
    sdram_xfer_model mem (.aclk(aclk), .aresetn(aresetn), .burst(nb), .start(go),
        .transfer_done(td));
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Write: both channels offered together, each released when taken
    task wr_reg(input logic [4:0] a, input logic [31:0] v);
        @(posedge aclk);
        {awa, wd, awv, wv, br} <= {a, v, 3'b111};
        do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end while (!bv);
        s = bresp;
        br <= 1'b0;
    endtask
    task rd_reg(input logic [4:0] a);
        @(posedge aclk);
        {ara, arv, rr} <= {a, 2'b11};
        do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
        end while (!rv);
        {d, s} = {rd, rresp};
        rr <= 1'b0;
    endtask
    // Run a burst of transfers and let the last pulse land
    task burst(input logic [9:0] n);
        @(posedge aclk);
        {nb, go} <= {n, 1'b1};
        @(posedge aclk);
        go <= 1'b0;
        repeat (n + 4) @(posedge aclk);
    endtask
    task t_locked;
        rd_reg(`OFS_TIMING_SECOND);
        chk("reset timing", d, 32'h01FF_FFFF);
        rd_reg(`OFS_STARVE_PRIO);
        chk("reset prio", d, 32'h0000_00FF);
        wr_reg(`OFS_TIMING_SECOND, 32'h0000_0000);
        chk("locked bresp", s, {30'h0, `RESP_OKAY});
        rd_reg(`OFS_TIMING_SECOND);
        chk("locked write", d, 32'h01FF_FFFF);
        rd_reg(`OFS_STATUS);
        chk("drop flag", d, 32'h0000_0001);
        $display("locked test done");
    endtask
    task t_fields;
        wr_reg(`OFS_CONFIG, 32'h0000_8000);
        wr_reg(`OFS_TIMING_SECOND, 32'hFFFF_FFFF);
        rd_reg(`OFS_TIMING_SECOND);
        chk("reserved timing", d, 32'h01FF_FFFF);
        wr_reg(`OFS_TIMING_SECOND, 32'h0125_A56A);
        chk("odt lead", odt, 32'h2);
        chk("xsnr", xsnr, 32'h25);
        chk("xsrd", xsrd, 32'hA5);
        chk("rtp", rtp, 32'h3);
        chk("cke", cke, 32'hA);
        rd_reg(5'h10);
        chk("unmapped", {d[29:0], s}, {30'h0, `RESP_SLVERR});
        $display("field test done");
    endtask
    task t_prio;
        wr_reg(`OFS_STARVE_PRIO, 32'hFFFF_FF02);
        rd_reg(`OFS_STARVE_PRIO);
        chk("reserved prio", d, 32'h0000_0002);
        n_pulse = 0;
        burst(10'd2);
        chk("two of three", n_pulse, 32'h0);
        burst(10'd1);
        chk("third xfer", n_pulse, 32'h1);
        wr_reg(`OFS_STARVE_PRIO, 32'h0000_0000);
        n_pulse = 0;
        burst(10'd3);
        chk("each xfer", n_pulse, 32'h3);
        // Clock enable low freezes the counter, so no pulse may appear
        ce <= 1'b0;
        n_pulse = 0;
        burst(10'd3);
        ce <= 1'b1;
        chk("frozen", n_pulse, 32'h0);
        wr_reg(`OFS_STARVE_PRIO, 32'h0000_00FF);
        n_pulse = 0;
        burst(10'd300);
        chk("promo off", n_pulse, 32'h0);
        $display("priority test done");
    endtask
    task conclude;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        t_locked();
        t_fields();
        t_prio();
        conclude();
    end
    // Watchdog well beyond the expected run of under a thousand cycles
    initial begin
        #200000;
        n_errors++;
        conclude();
    end
endmodule // ddr2_timing2_and_burst_priority_tb_top
`default_nettype wire
